// File: core/mvdec_pkg.sv
/*
 Constants shared by the move-instruction decoder and its testbench.
 Assumes nothing of its surroundings; holds definitions only.
*/
package mvdec_pkg;
    // ----------------------------------------------------------------
    // Instruction word layout
    // ----------------------------------------------------------------
    localparam int FMT_BIT = 15;
    localparam int DST_MOD_LO = 8;
    localparam int DST_IDX_LO = 12;
    localparam int SRC_IDX_LO = 4;
    localparam int MOD_W = 4;
    localparam int IDX_W = 5;
    // ----------------------------------------------------------------
    // Module numbers and index limits
    // ----------------------------------------------------------------
    localparam logic [3:0] MOD_PER_LAST = 4'h5;
    localparam logic [3:0] MOD_SYS_A = 4'h8;
    localparam logic [3:0] MOD_SYS_B = 4'h9;
    localparam logic [3:0] MOD_SYS_HI = 4'hb;
    localparam logic [3:0] MOD_EXT = 4'hb;
    localparam logic [3:0] MOD_PTR = 4'hf;
    localparam logic [4:0] SYS_IDX_N = 5'h10;
    localparam logic [4:0] FAST_WR_N = 5'h08;
    // ----------------------------------------------------------------
    // Pointer locations inside the pointer module
    // ----------------------------------------------------------------
    localparam logic [4:0] IDX_MEM_A = 5'h00;
    localparam logic [4:0] IDX_MEM_B = 5'h01;
    localparam logic [4:0] IDX_MEM_F = 5'h02;
    localparam logic [4:0] IDX_DPA = 5'h03;
    localparam logic [4:0] IDX_DPB = 5'h04;
    localparam logic [4:0] IDX_BASE = 5'h05;
    localparam logic [4:0] IDX_OFF = 5'h06;
    // ----------------------------------------------------------------
    // APB register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_DPA = 8'h08;
    localparam logic [7:0] ADDR_DPB = 8'h0c;
    localparam logic [7:0] ADDR_FRAME = 8'h10;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_DEC_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
endpackage

// File: core/mvdec_ptr.sv
/*
 Pointer unit: two stand-alone data pointers and a frame pointer made of
 a base and an 8-bit offset. Assumes one step per access, decided by the
 decoder in the same cycle.
*/
`timescale 1ns/1ps
module mvdec_ptr (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic step_dec,
    input wire logic [2:0] rd_sel,
    input wire logic [2:0] wr_sel,
    input wire logic ld_en,
    input wire logic [1:0] ld_sel,
    input wire logic [15:0] ld_data,
    output logic [15:0] data_pointer_a,
    output logic [15:0] data_pointer_b,
    output logic [15:0] frame_base,
    output logic [7:0] frame_offset,
    output logic [15:0] raddr,
    output logic [15:0] waddr
);
    typedef struct packed {
        logic [15:0] dpa;
        logic [15:0] dpb;
        logic [15:0] base;
        logic [7:0] off;
    } mvdec_ptr_st_t;

    mvdec_ptr_st_t st, next_st;
    logic [15:0] cur [3];
    logic [15:0] after [3];

    assign cur[0] = st.dpa;
    assign cur[1] = st.dpb;
    assign cur[2] = {8'h00, st.off};

    // ----------------------------------------------------------------
    // Step per pointer: post-step after a read, pre-step before a write
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_step
            logic [15:0] cnt;
            assign cnt = {14'h0000, {1'b0, rd_sel[g]} + {1'b0, wr_sel[g]}};
            assign after[g] = step_dec ? cur[g] - cnt : cur[g] + cnt;
        end
    endgenerate

    // Frame address only steps the offset; base is left alone
    always_comb begin
        raddr = 16'h0000;
        waddr = 16'h0000;
        if (rd_sel[0]) raddr = st.dpa;
        if (rd_sel[1]) raddr = st.dpb;
        if (rd_sel[2]) raddr = st.base + {8'h00, st.off};
        if (wr_sel[0]) waddr = after[0];
        if (wr_sel[1]) waddr = after[1];
        if (wr_sel[2]) waddr = st.base + {8'h00, after[2][7:0]};
    end

    always_comb begin
        next_st = st;
        next_st.dpa = after[0];
        next_st.dpb = after[1];
        next_st.off = after[2][7:0];
        // A direct load wins over a step of the same pointer
        if (ld_en) begin
            case (ld_sel)
                2'h0: next_st.dpa = ld_data;
                2'h1: next_st.dpb = ld_data;
                2'h2: next_st.base = ld_data;
                default: next_st.off = ld_data[7:0];
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign data_pointer_a = st.dpa;
    assign data_pointer_b = st.dpb;
    assign frame_base = st.base;
    assign frame_offset = st.off;
endmodule

// File: core/mvdec_top.sv
/*
 Move-instruction decoder: splits each word, applies the operand
 extension register, resolves width conversion and undefined locations,
 and drives the register modules and data memory in one cycle.
 Assumes register modules answer SRC_DATA and width flags combinationally.
*/
`timescale 1ns/1ps
module mvdec_top (
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [15:0] INSTR,
    input wire logic INSTR_VALID,
    output logic [3:0] SRC_MOD,
    output logic [4:0] SRC_IDX,
    output logic SRC_RD,
    input wire logic [15:0] SRC_DATA,
    input wire logic SRC_IS16,
    input wire logic SRC_DEFINED,
    input wire logic SRC_HAS8,
    output logic [3:0] DST_MOD,
    output logic [4:0] DST_IDX,
    output logic DST_WR,
    output logic [15:0] DST_DATA,
    input wire logic DST_IS16,
    input wire logic DST_DEFINED,
    output logic SYS_OP,
    output logic MEM_RD,
    output logic [15:0] MEM_RADDR,
    input wire logic [15:0] MEM_RDATA,
    output logic MEM_WE,
    output logic [15:0] MEM_WADDR,
    output logic [15:0] MEM_WDATA,
    output logic EXT_ACTIVE
);
    typedef struct packed {
        logic ext_valid;
        logic [7:0] ext_data;
        logic ext_sidx;
        logic [1:0] ext_didx;
        logic [1:0] ctrl;
        logic last_src_undef;
        logic last_dst_undef;
        logic [31:0] prdata;
        logic pslverr;
    } mvdec_st_t;

    mvdec_st_t st, next_st;

    logic go;
    logic fmt_reg;
    logic [3:0] smod, dmod;
    logic [4:0] sidx, didx;
    logic src_int, src_mem, src_preg, src_def, src16, src_has8;
    logic dst_ext, dst_mem, dst_preg, dst_def, dst16, dst_extern;
    logic [15:0] raw, src_val, xfer;
    logic [2:0] rd_sel, wr_sel;
    logic [15:0] dpa, dpb, fbase;
    logic [7:0] foff;
    logic setup;

    function automatic logic is_sys(input logic [3:0] m);
        return (m == mvdec_pkg::MOD_SYS_A) || (m == mvdec_pkg::MOD_SYS_B) ||
               (m >= mvdec_pkg::MOD_SYS_HI);
    endfunction

    function automatic logic is_per(input logic [3:0] m);
        return m <= mvdec_pkg::MOD_PER_LAST;
    endfunction

    // System modules stop at 16 indexes, peripherals use all 32
    function automatic logic idx_ok(input logic [3:0] m, input logic [4:0] i);
        return is_sys(m) ? (i < mvdec_pkg::SYS_IDX_N) : is_per(m);
    endfunction

    // ----------------------------------------------------------------
    // Word split
    // ----------------------------------------------------------------
    // One word per instruction, consumed in the cycle it is offered while the enable bit is set
    assign go = INSTR_VALID && st.ctrl[mvdec_pkg::CTRL_EN_BIT];
    assign fmt_reg = INSTR[mvdec_pkg::FMT_BIT];
    // Destination index gets its top bits from the extension
    assign dmod = INSTR[mvdec_pkg::DST_MOD_LO +: mvdec_pkg::MOD_W];
    assign didx = {st.ext_didx, INSTR[mvdec_pkg::DST_IDX_LO +: 3]};
    // Source index bit 4 only comes from the extension
    assign smod = INSTR[3:0];
    assign sidx = {st.ext_sidx, INSTR[mvdec_pkg::SRC_IDX_LO +: 4]};

    // ----------------------------------------------------------------
    // Source resolution
    // ----------------------------------------------------------------
    assign src_mem = (smod == mvdec_pkg::MOD_PTR) && (sidx <= mvdec_pkg::IDX_MEM_F);
    assign src_preg = (smod == mvdec_pkg::MOD_PTR) && (sidx >= mvdec_pkg::IDX_DPA) &&
                      (sidx <= mvdec_pkg::IDX_OFF);
    assign src_int = (smod == mvdec_pkg::MOD_PTR) || (smod == mvdec_pkg::MOD_EXT);

    always_comb begin
        raw = 16'h0000;
        src16 = 1'b0;
        src_def = 1'b1;
        src_has8 = 1'b0;
        if (!fmt_reg) begin
            raw = {8'h00, INSTR[7:0]};
        end else if (src_mem) begin
            raw = MEM_RDATA;
            src16 = 1'b1;
        end else if (src_preg) begin
            src16 = 1'b1;
            case (sidx)
                mvdec_pkg::IDX_DPA: raw = dpa;
                mvdec_pkg::IDX_DPB: raw = dpb;
                mvdec_pkg::IDX_BASE: raw = fbase;
                default: begin
                    raw = {8'h00, foff};
                    src16 = 1'b0;
                end
            endcase
        end else if (src_int) begin
            src_def = 1'b0;
            src_has8 = (smod == mvdec_pkg::MOD_PTR);
        end else begin
            // Register modules answer in the same cycle
            raw = SRC_DATA;
            src16 = SRC_IS16;
            src_def = SRC_DEFINED && idx_ok(smod, sidx);
            src_has8 = SRC_HAS8;
        end
    end

    // Undefined source depends on whether the module holds any 8-bit register
    always_comb begin
        src_val = raw;
        if (!src_def) begin
            src_val = src_has8 ? {st.ext_data, 8'h00} : 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // Destination resolution
    // ----------------------------------------------------------------
    assign dst_ext = (dmod == mvdec_pkg::MOD_EXT);
    assign dst_mem = (dmod == mvdec_pkg::MOD_PTR) && (didx <= mvdec_pkg::IDX_MEM_F);
    assign dst_preg = (dmod == mvdec_pkg::MOD_PTR) && (didx >= mvdec_pkg::IDX_DPA) &&
                      (didx <= mvdec_pkg::IDX_OFF);
    assign dst_extern = !dst_ext && (dmod != mvdec_pkg::MOD_PTR);

    always_comb begin
        dst_def = 1'b1;
        dst16 = 1'b1;
        if (dst_ext) begin
            dst16 = 1'b0;
        end else if (dst_preg) begin
            dst16 = (didx != mvdec_pkg::IDX_OFF);
        end else if (!dst_mem && !dst_extern) begin
            dst_def = 1'b0;
        end else if (dst_extern) begin
            dst_def = DST_DEFINED && idx_ok(dmod, didx);
            dst16 = DST_IS16;
        end
    end

    // Width conversion; an 8-bit destination never keeps a high byte
    always_comb begin
        if (!dst16) begin
            xfer = {8'h00, src_val[7:0]};
        end else if (!src_def || src16) begin
            xfer = src_val;
        end else begin
            xfer = {st.ext_data, src_val[7:0]};
        end
    end

    // ----------------------------------------------------------------
    // Strobes toward register modules and memory
    // ----------------------------------------------------------------
    assign SRC_MOD = smod;
    assign SRC_IDX = sidx;
    assign DST_MOD = dmod;
    assign DST_IDX = didx;
    assign DST_DATA = xfer;
    // Source read still fires when the destination is undefined
    assign SRC_RD = go && fmt_reg && !src_int;
    assign DST_WR = go && dst_extern && dst_def;
    // Unused system locations carry the higher-level ops
    assign SYS_OP = go && dst_extern && !dst_def && is_sys(dmod);
    assign MEM_RD = go && fmt_reg && src_mem;
    assign MEM_WE = go && dst_mem;
    assign MEM_WDATA = xfer;
    assign EXT_ACTIVE = st.ext_valid;

    // Pointer steps go to the selected pointer only
    assign rd_sel = MEM_RD ? (3'b001 << sidx[1:0]) : 3'b000;
    assign wr_sel = MEM_WE ? (3'b001 << didx[1:0]) : 3'b000;

    mvdec_ptr u_ptr (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .step_dec(st.ctrl[mvdec_pkg::CTRL_DEC_BIT]),
        .rd_sel(rd_sel),
        .wr_sel(wr_sel),
        .ld_en(go && dst_preg),
        .ld_sel(2'(didx - mvdec_pkg::IDX_DPA)),
        .ld_data(xfer),
        .data_pointer_a(dpa),
        .data_pointer_b(dpb),
        .frame_base(fbase),
        .frame_offset(foff),
        .raddr(MEM_RADDR),
        .waddr(MEM_WADDR)
    );

    // ----------------------------------------------------------------
    // Next state: extension register, status, APB slave
    // ----------------------------------------------------------------
    assign setup = PSEL && !PENABLE;

    always_comb begin
        next_st = st;
        // Extension lives one cycle; a new write replaces it
        next_st.ext_valid = 1'b0;
        next_st.ext_data = 8'h00;
        next_st.ext_sidx = 1'b0;
        next_st.ext_didx = 2'h0;
        if (go && dst_ext) begin
            next_st.ext_valid = 1'b1;
            next_st.ext_data = xfer[7:0];
            next_st.ext_sidx = didx[2];
            next_st.ext_didx = didx[1:0];
        end
        if (go) begin
            next_st.last_src_undef = fmt_reg && !src_def;
            next_st.last_dst_undef = !dst_def;
        end
        // Read data is latched in setup so the access phase answers from flops
        if (setup) begin
            next_st.pslverr = 1'b0;
            next_st.prdata = 32'h0000_0000;
            if (PADDR == mvdec_pkg::ADDR_CTRL) begin
                next_st.prdata = {30'h0, st.ctrl};
            end else if (PADDR == mvdec_pkg::ADDR_STAT) begin
                next_st.prdata = {21'h0, st.ext_valid, st.ext_data, st.last_src_undef,
                                  st.last_dst_undef};
            end else if (PADDR == mvdec_pkg::ADDR_DPA) begin
                next_st.prdata = {16'h0, dpa};
            end else if (PADDR == mvdec_pkg::ADDR_DPB) begin
                next_st.prdata = {16'h0, dpb};
            end else if (PADDR == mvdec_pkg::ADDR_FRAME) begin
                next_st.prdata = {8'h0, foff, fbase};
            end else begin
                next_st.pslverr = 1'b1;
            end
        end
        if (PSEL && PENABLE && PWRITE && (PADDR == mvdec_pkg::ADDR_CTRL)) begin
            next_st.ctrl = PWDATA[1:0];
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st <= '0;
            st.ctrl <= mvdec_pkg::CTRL_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign PREADY = PSEL && PENABLE;
    assign PRDATA = (PSEL && PENABLE && !PWRITE) ? st.prdata : 32'h0000_0000;
    assign PSLVERR = PSEL && PENABLE && st.pslverr;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);

    a_ext_one_cycle: assert property (st.ext_valid && !(go && dst_ext) |=> !st.ext_valid)
        else $error("extension survived past one instruction");
    a_ext_from_write: assert property ($rose(st.ext_valid) |-> $past(go && dst_ext))
        else $error("extension set without a write");
    a_imm_wide: assert property (DST_WR && !INSTR[15] && DST_IS16 |->
                                 DST_DATA == {st.ext_data, INSTR[7:0]})
        else $error("immediate high byte not from extension");
    a_dst_split: assert property (go |-> DST_MOD == INSTR[11:8] &&
                                  DST_IDX[2:0] == INSTR[14:12])
        else $error("destination field split wrong");
    a_src_split: assert property (go |-> SRC_MOD == INSTR[3:0] &&
                                  SRC_IDX[3:0] == INSTR[7:4])
        else $error("source field split wrong");
    a_narrow_dst: assert property (DST_WR && !DST_IS16 |-> DST_DATA[15:8] == 8'h00)
        else $error("narrow destination got high byte");
    a_wide_copy: assert property (DST_WR && SRC_RD && SRC_IS16 && DST_IS16 && src_def |->
                                  DST_DATA == SRC_DATA)
        else $error("wide move altered data");
    a_undef_nowr: assert property (go && !DST_DEFINED |-> !DST_WR)
        else $error("write to undefined destination");
    a_per_no_op: assert property (SYS_OP |-> DST_MOD > 4'h5)
        else $error("peripheral module raised an op");
    a_hi_idx_ext: assert property (DST_WR && DST_IDX >= mvdec_pkg::FAST_WR_N |->
                                   $past(go && dst_ext))
        else $error("high index written without extension");
    a_ptr_post: assert property (MEM_RD && SRC_IDX == 5'h00 && !MEM_WE && !(go && dst_preg) |->
                                 MEM_RADDR == dpa ##1 dpa != $past(dpa))
        else $error("data pointer did not step after read");

    c_imm16: cover property (go && dst_ext ##1 DST_WR && !INSTR[15] && DST_IS16);
    c_undef_dst: cover property (SRC_RD && !DST_WR && !SYS_OP);
    c_mem_read: cover property (MEM_RD);
    c_sys_op: cover property (SYS_OP);
endmodule

// File: verif/mvdec_regs.sv
/*
 Behavioural register modules and data memory facing the move decoder.
 Assumes the decoder drives selects and strobes combinationally; answers in the same cycle.
*/
`timescale 1ns/1ps
module mvdec_regs (
    input wire logic [3:0] src_mod,
    input wire logic [4:0] src_idx,
    output logic [15:0] src_data,
    output logic src_is16,
    output logic src_defined,
    output logic src_has8,
    input wire logic [3:0] dst_mod,
    input wire logic [4:0] dst_idx,
    output logic dst_is16,
    output logic dst_defined,
    input wire logic mem_rd,
    input wire logic [15:0] mem_raddr,
    output logic [15:0] mem_rdata
);
    // ----------------------------------------------------------------
    // Module 0: 8-bit at 0..3, 16-bit above, 7 empty; module 1: 16-bit, 2 empty
    // ----------------------------------------------------------------
    logic [15:0] val;
    assign val = {3'h5, src_idx, src_mod, 4'ha};
    assign src_defined = (src_mod == 4'h0 && src_idx != 5'h07) ||
                         (src_mod == 4'h1 && src_idx != 5'h02);
    assign src_is16 = !(src_mod == 4'h0 && src_idx < 5'h04);
    assign src_has8 = (src_mod == 4'h0);
    // An 8-bit source leaves its high byte undriven, so show junk there, not zero
    assign src_data = !src_defined ? ~val : (src_is16 ? val : {~val[7:0], val[7:0]});
    assign dst_defined = (dst_mod == 4'h0 && dst_idx != 5'h07) ||
                         (dst_mod == 4'h1 && dst_idx != 5'h02);
    assign dst_is16 = !(dst_mod == 4'h0 && dst_idx < 5'h04);
    // Memory outside a read shows the inverted read address, not read data
    assign mem_rdata = mem_rd ? (mem_raddr ^ 16'h5a5a) : ~mem_raddr;
endmodule

// File: verif/testbench.sv
/*
 Self-checking bench for the move decoder with the register model beside it.
 Assumes the APB slave answers in its own time and strobes settle within the instruction cycle.
*/
`timescale 1ns/1ps
module testbench;
    logic REF_CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, INSTR_VALID, e;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, r;
    logic [15:0] INSTR, SRC_DATA, DST_DATA, MEM_RADDR, MEM_RDATA, MEM_WADDR, MEM_WDATA;
    logic [3:0] SRC_MOD, DST_MOD;
    logic [4:0] SRC_IDX, DST_IDX;
    logic SRC_RD, SRC_IS16, SRC_DEFINED, SRC_HAS8, DST_WR, DST_IS16, DST_DEFINED;
    logic SYS_OP, MEM_RD, MEM_WE, EXT_ACTIVE;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    mvdec_top dut_u (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID), .SRC_MOD(SRC_MOD),
        .SRC_IDX(SRC_IDX), .SRC_RD(SRC_RD), .SRC_DATA(SRC_DATA), .SRC_IS16(SRC_IS16),
        .SRC_DEFINED(SRC_DEFINED), .SRC_HAS8(SRC_HAS8), .DST_MOD(DST_MOD), .DST_IDX(DST_IDX),
        .DST_WR(DST_WR), .DST_DATA(DST_DATA), .DST_IS16(DST_IS16), .DST_DEFINED(DST_DEFINED),
        .SYS_OP(SYS_OP), .MEM_RD(MEM_RD), .MEM_RADDR(MEM_RADDR), .MEM_RDATA(MEM_RDATA),
        .MEM_WE(MEM_WE), .MEM_WADDR(MEM_WADDR), .MEM_WDATA(MEM_WDATA), .EXT_ACTIVE(EXT_ACTIVE));
    mvdec_regs regs_u (.src_mod(SRC_MOD), .src_idx(SRC_IDX), .src_data(SRC_DATA),
        .src_is16(SRC_IS16), .src_defined(SRC_DEFINED), .src_has8(SRC_HAS8),
        .dst_mod(DST_MOD), .dst_idx(DST_IDX), .dst_is16(DST_IS16), .dst_defined(DST_DEFINED),
        .mem_rd(MEM_RD), .mem_raddr(MEM_RADDR), .mem_rdata(MEM_RDATA));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        check_count++;
        if (g !== x) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    // Instruction stays valid until the next call or an APB transfer lowers it
    task automatic ex(input logic [15:0] i);
        @(posedge REF_CLK);
        INSTR <= i;
        INSTR_VALID <= 1'b1;
        @(negedge REF_CLK);
    endtask
    // Request holds until PREADY is seen at a rising edge; the hang guard ends a stuck wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        INSTR_VALID <= 1'b0;
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge REF_CLK);
        end while (PREADY !== 1'b1);
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_apb();
        apb(1'b0, mvdec_pkg::ADDR_CTRL, 32'h0);
        chk(r, {30'h0, mvdec_pkg::CTRL_RESET}, "ctrl reset");
        apb(1'b0, 8'hfc, 32'h0);
        chk(e, 1'b1, "unmapped no error");
        apb(1'b1, mvdec_pkg::ADDR_DPA, 32'hffff);
        apb(1'b0, mvdec_pkg::ADDR_DPA, 32'h0);
        chk(r, 32'h0, "read-only pointer written");
        $display("test done: apb");
    endtask
    task automatic t_imm();
        ex(16'h4034);
        chk({DST_WR, SRC_RD, DST_MOD, DST_IDX}, {2'b10, 4'h0, 5'h04}, "imm");
        chk(DST_DATA, 16'h0034, "imm no ext");
        ex(16'h0b12);
        ex(16'h4034);
        chk({EXT_ACTIVE, DST_DATA}, {1'b1, 16'h1234}, "imm with ext");
        ex(16'h4034);
        chk({EXT_ACTIVE, DST_DATA}, {1'b0, 16'h0034}, "ext lingered");
        ex(16'h0b12);
        apb(1'b0, mvdec_pkg::ADDR_STAT, 32'h0);
        chk(r, 32'h0000_0448, "status extension");
        $display("test done: imm");
    endtask
    task automatic t_reg();
        ex(16'h9031);
        chk({SRC_RD, SRC_MOD, SRC_IDX}, {1'b1, 4'h1, 5'h03}, "src select");
        chk(DST_DATA[7:0], 8'h1a, "16 to 8");
        ex(16'hb120);
        chk(DST_DATA, 16'h000a, "8 to 16");
        ex(16'h9020);
        chk(DST_DATA[7:0], 8'h0a, "8 to 8");
        ex(16'hb151);
        chk({DST_WR, DST_DATA}, {1'b1, 16'ha51a}, "16 to 16");
        ex(16'h2b00);
        ex(16'h3056);
        chk({DST_WR, DST_IDX}, {1'b1, 5'h13}, "upper dest index");
        ex(16'h4b00);
        ex(16'hb111);
        chk(SRC_IDX, 5'h11, "upper src index");
        apb(1'b0, mvdec_pkg::ADDR_STAT, 32'h0);
        chk(r, 32'h0, "upper src index undefined");
        $display("test done: reg");
    endtask
    task automatic t_undef();
        ex(16'h7055);
        chk({DST_WR, SYS_OP}, 2'b00, "undefined peripheral dest");
        ex(16'h7800);
        chk(SYS_OP, 1'b1, "system op strobe");
        ex(16'hf00f);
        chk({DST_WR, MEM_RD, MEM_RADDR}, {2'b01, 16'h0}, "dummy move read");
        ex(16'hb170);
        chk(DST_DATA, 16'h0000, "undef 8-bit src");
        ex(16'h0b12);
        ex(16'hb170);
        chk(DST_DATA, 16'h1200, "undef 8-bit src ext");
        ex(16'h0b12);
        ex(16'hb121);
        chk(DST_DATA, 16'h0000, "undef 16-bit src");
        apb(1'b0, mvdec_pkg::ADDR_STAT, 32'h0);
        chk(r, 32'h2, "undefined source not flagged");
        apb(1'b0, mvdec_pkg::ADDR_DPA, 32'h0);
        chk(r, 32'h1, "post step on read");
        $display("test done: undef");
    endtask
    task automatic t_ptr();
        ex(16'h0f77);
        chk({MEM_WE, MEM_WADDR, MEM_WDATA}, {1'b1, 16'h0002, 16'h0077}, "pre step");
        ex(16'hb12f);
        chk({MEM_RD, MEM_RADDR, DST_DATA}, {1'b1, 16'h0, 16'h5a5a}, "frame read");
        apb(1'b0, mvdec_pkg::ADDR_FRAME, 32'h0);
        chk(r, 32'h0001_0000, "frame offset step");
        apb(1'b1, mvdec_pkg::ADDR_CTRL, 32'h0);
        ex(16'h4034);
        chk({DST_WR, MEM_WE}, 2'b00, "disabled decoder strobed");
        apb(1'b1, mvdec_pkg::ADDR_CTRL, 32'h3);
        ex(16'hb11f);
        apb(1'b0, mvdec_pkg::ADDR_DPB, 32'h0);
        chk(r, 32'h0000_ffff, "pointer b post decrement");
        $display("test done: ptr");
    endtask
    initial begin
        REF_CLK = 1'b0;
        forever #4 REF_CLK = ~REF_CLK;
    end
    // Hang guard well above the roughly 70 cycles the scenarios need
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        ARST_N = 1'b0;
        {PSEL, PENABLE, PWRITE, INSTR_VALID} = 4'h0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        INSTR = 16'h0000;
        repeat (10) @(posedge REF_CLK);
        ARST_N <= 1'b1;
        t_apb();
        t_imm();
        t_reg();
        t_undef();
        t_ptr();
        stop_test();
    end
endmodule
